/* File: inc/uefa_pkg.sv */
// Shared constants of the endpoint FIFO allocator and its configuring controller.
package uefa_pkg;
  // ****************************************************************
  // Endpoint set and storage limits.
  // ****************************************************************
  localparam int          EP_COUNT      = 16;     // Index 0 ctl OUT, 1 ctl IN, 2..15 ep 1..14.
  localparam logic [3:0]  PROG_FIRST    = 4'h2;
  localparam logic [3:0]  LAST_IDX      = 4'hF;
  localparam logic [3:0]  CTL_OUT_IDX   = 4'h0;
  localparam logic [3:0]  CTL_IN_IDX    = 4'h1;
  localparam int          SUM_W         = 15;
  localparam int          PKT_W         = 11;
  localparam logic [SUM_W-1:0] CTL_BYTES  = 15'h0040;
  localparam logic [SUM_W-1:0] CTL_PAIR   = 15'h0080;
  localparam logic [SUM_W-1:0] TOTAL_MAX  = 15'h099E;  // 2462 bytes.
  localparam logic [SUM_W-1:0] NONISO_MAX = 15'h0200;  // 512 bytes.
  // ****************************************************************
  // Endpoint configuration and DMA configuration layout.
  // ****************************************************************
  localparam int          ECR_W         = 8;
  localparam int          ECR_EN_BIT    = 7;
  localparam int          ECR_DIR_BIT   = 6;      // 1 is IN, device transmits.
  localparam int          ECR_ISO_BIT   = 5;
  localparam int          ECR_DBL_BIT   = 4;
  localparam int          ECR_SZ_LSB    = 0;
  localparam int          SZ_W          = 4;
  localparam logic [7:0]  ECR_RST       = 8'h00;
  localparam logic [3:0]  NONISO_TOP    = 4'h3;
  localparam int          DMA_EN_BIT    = 4;
  localparam logic [7:0]  DMA_RST       = 8'h00;
  // ****************************************************************
  // Controller register map and status bits.
  // ****************************************************************
  localparam int          RA_W          = 5;
  localparam int          RD_W          = 16;
  localparam logic [4:0]  RA_SHADOW_TOP = 5'h0F;  // 0x00..0x0F hold the 16 values.
  localparam logic [4:0]  RA_CTRL       = 5'h10;
  localparam logic [4:0]  RA_DMA        = 5'h11;
  localparam logic [4:0]  RA_STATUS     = 5'h12;
  localparam logic [4:0]  RA_TOTAL      = 5'h13;
  localparam logic [4:0]  RA_NONISO     = 5'h14;
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_ENUM_BIT = 1;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_OK_BIT     = 1;
  localparam int          ST_ERR_BIT    = 2;
  localparam int          ST_REF_BIT    = 3;
  localparam int          ST_VALID_BIT  = 4;

  // Logical FIFO size in bytes; reserved non-isochronous codes give zero.
  function automatic logic [PKT_W-1:0] uefa_logical_size(input logic iso,
                                                         input logic [SZ_W-1:0] code);
    logic [PKT_W-1:0] r;
    r = 11'h000;
    if (!iso)
    begin
      case (code)
        4'h0: r = 11'h008;
        4'h1: r = 11'h010;
        4'h2: r = 11'h020;
        4'h3: r = 11'h040;
        default: r = 11'h000;
      endcase
    end
    else
    begin
      case (code)
        4'h0: r = 11'h010;
        4'h1: r = 11'h020;
        4'h2: r = 11'h030;
        4'h3: r = 11'h040;
        4'h4: r = 11'h060;
        4'h5: r = 11'h080;
        4'h6: r = 11'h0A0;
        4'h7: r = 11'h0C0;
        4'h8: r = 11'h100;
        4'h9: r = 11'h140;
        4'hA: r = 11'h180;
        4'hB: r = 11'h200;
        4'hC: r = 11'h280;
        4'hD: r = 11'h300;
        4'hE: r = 11'h380;
        default: r = 11'h3FF;
      endcase
    end
    return r;
  endfunction
endpackage

/* File: inc/uefa_link_if.sv */
// Link between the endpoint FIFO allocator and its configuring controller.
`timescale 1ns/100ps
`default_nettype none
interface uefa_link_if;
  import uefa_pkg::*;
  logic             ecr_wr;        // Controller writes one configuration value.
  logic [3:0]       ecr_idx;
  logic [ECR_W-1:0] ecr_data;
  logic             dma_wr;        // Controller writes the DMA configuration.
  logic [7:0]       dma_data;
  logic             ctl_zlp;       // Pulse: send empty packet on control IN.
  logic             ctl_stall;     // Pulse: stall control IN.
  logic             alloc_busy;
  logic             alloc_done;
  logic             size_err;
  logic [SUM_W-1:0] total_phys;
  logic [SUM_W-1:0] noniso_phys;
  logic             data_present;

  modport dev (input ecr_wr, ecr_idx, ecr_data, dma_wr, dma_data, ctl_zlp, ctl_stall,
               output alloc_busy, alloc_done, size_err, total_phys, noniso_phys,
               data_present);
  modport host (output ecr_wr, ecr_idx, ecr_data, dma_wr, dma_data, ctl_zlp, ctl_stall,
                input alloc_busy, alloc_done, size_err, total_phys, noniso_phys,
                data_present);
endinterface
`default_nettype wire

/* File: verilog/uefa_host.sv */
// Configuring controller: programs all endpoint values and judges the result.
`timescale 1ns/100ps
`default_nettype none
module uefa_host
  import uefa_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  uefa_link_if.host            link,
  input  wire logic [RA_W-1:0] addr_i,
  input  wire logic [RD_W-1:0] wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [RD_W-1:0] rdata_o
);
  // ****************************************************************
  // Register port.
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_WRITE = 4'b0010,
    S_WAIT  = 4'b0100,
    S_CHECK = 4'b1000
  } uefa_hst_e;

  uefa_hst_e        st_q;
  logic [ECR_W-1:0] shadow_q [EP_COUNT];
  logic [3:0]       idx_q;
  logic [3:0]       ecr_idx_q;
  logic             enum_q, ok_q, err_q, ref_q;
  logic             ecr_wr_q, dma_wr_q, zlp_q, stall_q;
  logic [ECR_W-1:0] ecr_data_q;
  logic [7:0]       dma_data_q;
  logic             go;
  logic             ok_now;

  assign go = wr_i && addr_i == RA_CTRL && wdata_i[CTRL_GO_BIT];
  assign ok_now = !link.size_err && link.total_phys <= TOTAL_MAX
                  && link.noniso_phys <= NONISO_MAX;

  // Shadow values and the enumeration flag are plain software storage.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < EP_COUNT; i++)
        shadow_q[i] <= ECR_RST;
      enum_q <= 1'b0;
    end
    else if (wr_i && addr_i <= RA_SHADOW_TOP)
      shadow_q[addr_i[3:0]] <= wdata_i[ECR_W-1:0];
    else if (wr_i && addr_i == RA_CTRL)
      enum_q <= wdata_i[CTRL_ENUM_BIT];
  end

  // Sequencer; a start while busy or with data buffered is refused.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q     <= S_IDLE;
      idx_q    <= 4'h0;
      ecr_idx_q <= 4'h0;
      ecr_wr_q <= 1'b0;
      ecr_data_q <= ECR_RST;
      zlp_q    <= 1'b0;
      stall_q  <= 1'b0;
      ok_q     <= 1'b0;
      err_q    <= 1'b0;
    end
    else
    begin
      ecr_wr_q <= 1'b0;
      zlp_q    <= 1'b0;
      stall_q  <= 1'b0;
      case (st_q)
        S_IDLE:
          if (go && !link.data_present)
          begin
            st_q  <= S_WRITE;
            idx_q <= 4'h0;
            ok_q  <= 1'b0;
            err_q <= 1'b0;
          end
        S_WRITE:
        begin
          ecr_wr_q   <= 1'b1;
          ecr_data_q <= shadow_q[idx_q];
          ecr_idx_q  <= idx_q;
          idx_q      <= idx_q + 4'h1;
          if (idx_q == LAST_IDX)
            st_q <= S_WAIT;
        end
        S_WAIT:
          if (!ecr_wr_q && link.alloc_done && !link.alloc_busy)
            st_q <= S_CHECK;
        S_CHECK:
        begin
          st_q    <= S_IDLE;
          ok_q    <= ok_now;
          err_q   <= !ok_now;
          zlp_q   <= ok_now;
          stall_q <= !ok_now;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Refusal flag; a new refusal wins over a write-one clear.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      ref_q <= 1'b0;
    else if (go && (st_q != S_IDLE || link.data_present))
      ref_q <= 1'b1;
    else if (wr_i && addr_i == RA_STATUS && wdata_i[ST_REF_BIT])
      ref_q <= 1'b0;
  end

  // DMA configuration passes straight through as one write.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dma_wr_q   <= 1'b0;
      dma_data_q <= DMA_RST;
    end
    else
    begin
      dma_wr_q <= wr_i && addr_i == RA_DMA;
      if (wr_i && addr_i == RA_DMA)
        dma_data_q <= wdata_i[7:0];
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      rdata_o <= 16'h0000;
      if (addr_i <= RA_SHADOW_TOP)
        rdata_o <= {8'h00, shadow_q[addr_i[3:0]]};
      else if (addr_i == RA_CTRL)
        rdata_o <= {14'h0000, enum_q, 1'b0};
      else if (addr_i == RA_DMA)
        rdata_o <= {8'h00, dma_data_q};
      else if (addr_i == RA_STATUS)
        rdata_o <= {11'h000, ok_q && enum_q, ref_q, err_q, ok_q,
                    st_q != S_IDLE};
      else if (addr_i == RA_TOTAL)
        rdata_o <= {1'b0, link.total_phys};
      else if (addr_i == RA_NONISO)
        rdata_o <= {1'b0, link.noniso_phys};
    end
  end

  assign link.ecr_wr    = ecr_wr_q;
  assign link.ecr_idx   = ecr_idx_q;
  assign link.ecr_data  = ecr_data_q;
  assign link.dma_wr    = dma_wr_q;
  assign link.dma_data  = dma_data_q;
  assign link.ctl_zlp   = zlp_q;
  assign link.ctl_stall = stall_q;
endmodule // uefa_host
`default_nettype wire

/* File: verilog/uefa_device.sv */
// Endpoint set and shared FIFO allocator of the device.
// What this block does
// - Endpoint zero pair: fixed 64 bytes, no DMA.
// - Fourteen endpoints, type and direction each free.
// - All endpoints by I/O; 1 to 14 DMA.
// - DMA chosen by index field and enable bit.
// - Controller keeps total storage at most 2462.
// - Controller keeps non-isochronous storage at most 512.
// - Only enabled endpoints get storage.
// - Configured size is the largest packet.
// - Allocation uses only enable, size, isochronous.
// - Size code decodes per isochronous table.
// - Double buffering doubles storage, done in hardware.
// - No reallocation while any FIFO holds data.
// - Controller writes all sixteen values in order.
// - Storage assigned automatically after the writes.
// - Success answered by empty control IN packet.
// - Errors answered by stalling control IN.
// - Resets clear configuration; control endpoint stays.
// - Configuration counts only after enumeration.
// - Direction bit: IN transmits, OUT receives.
// - Endpoint known by address, number, direction.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module uefa_device
  import uefa_pkg::*;
#(
  parameter int EP_N = EP_COUNT
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  uefa_link_if.dev              link,
  input  wire logic             usb_bus_reset_i,
  input  wire logic             fifo_data_present_i,
  input  wire logic [3:0]       qry_idx_i,
  output logic      [SUM_W-1:0] qry_base_o,
  output logic      [PKT_W-1:0] qry_max_pkt_o,
  output logic                  qry_enabled_o,
  output logic                  qry_direction_o,
  output logic      [3:0]       dma_endpoint_index_o,
  output logic                  dma_sel_valid_o,
  output logic                  dma_write_o,
  input  wire logic [6:0]       dev_addr_i,
  input  wire logic [6:0]       tok_addr_i,
  input  wire logic [3:0]       tok_ep_i,
  input  wire logic             tok_in_i,
  output logic                  tok_match_o,
  output logic      [3:0]       tok_idx_o,
  output logic                  ctl_in_stalled_o,
  output logic                  ctl_in_zlp_o
);
  // ****************************************************************
  // Configuration storage.
  // ****************************************************************
  if (EP_N != EP_COUNT)
  begin : g_check
    $error("uefa_device serves exactly sixteen endpoint entries");
  end

  logic [ECR_W-1:0] ecr_q [EP_COUNT];
  logic [7:0]       dma_cfg_q;
  logic             clr;

  assign clr = !rst_n_i || usb_bus_reset_i;

  // One entry per endpoint; control entries are never used for allocation.
  for (genvar g = 0; g < EP_COUNT; g++)
  begin : g_ecr
    always_ff @(posedge clk_i)
    begin
      if (clr)
        ecr_q[g] <= ECR_RST;
      else if (link.ecr_wr && link.ecr_idx == 4'(g))
        ecr_q[g] <= link.ecr_data;
    end
  end

  // DMA configuration is cleared by either reset as well.
  always_ff @(posedge clk_i)
  begin
    if (clr)
      dma_cfg_q <= DMA_RST;
    else if (link.dma_wr)
      dma_cfg_q <= link.dma_data;
  end

  // ****************************************************************
  // Allocation walker.
  // ****************************************************************
  logic [SUM_W-1:0] base_q [EP_COUNT];
  logic [SUM_W-1:0] acc_tot_q, acc_non_q, tot_q, non_q;
  logic [3:0]       walk_q;
  logic             busy_q, done_q, err_q;
  logic [ECR_W-1:0] cur;
  logic [PKT_W-1:0] cur_log;
  logic [SUM_W-1:0] cur_phys;
  logic             cur_en, cur_iso;

  // Only enable, size and isochronous choose the amount; double buffer doubles it.
  assign cur      = ecr_q[walk_q];
  assign cur_en   = cur[ECR_EN_BIT];
  assign cur_iso  = cur[ECR_ISO_BIT];
  assign cur_log  = uefa_logical_size(cur_iso, cur[ECR_SZ_LSB +: SZ_W]);
  assign cur_phys = !cur_en ? '0 :
                    cur[ECR_DBL_BIT] ? {3'b000, cur_log, 1'b0} :
                    {4'h0, cur_log};

  // Starts when the last value is written; a fresh write of it restarts the walk, other writes hold it.
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      walk_q    <= PROG_FIRST;
      acc_tot_q <= CTL_PAIR;
      acc_non_q <= CTL_PAIR;
      tot_q     <= CTL_PAIR;
      non_q     <= CTL_PAIR;
      for (int i = 0; i < EP_COUNT; i++)
        base_q[i] <= '0;
      base_q[CTL_IN_IDX] <= CTL_BYTES;
    end
    else if (link.ecr_wr && link.ecr_idx == LAST_IDX)
    begin
      busy_q    <= 1'b1;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      walk_q    <= PROG_FIRST;
      acc_tot_q <= CTL_PAIR;
      acc_non_q <= CTL_PAIR;
    end
    else if (link.ecr_wr)
      done_q <= 1'b0;
    else if (busy_q)
    begin
      base_q[walk_q] <= acc_tot_q;
      acc_tot_q      <= acc_tot_q + cur_phys;
      if (!cur_iso)
        acc_non_q <= acc_non_q + cur_phys;
      if (cur_en && !cur_iso && cur[ECR_SZ_LSB +: SZ_W] > NONISO_TOP)
        err_q <= 1'b1;
      if (walk_q == LAST_IDX)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        tot_q  <= acc_tot_q + cur_phys;
        non_q  <= cur_iso ? acc_non_q : acc_non_q + cur_phys;
      end
      else
        walk_q <= walk_q + 4'h1;
    end
  end

  // ****************************************************************
  // Query, DMA selection and token match.
  // ****************************************************************
  logic [ECR_W-1:0] q_ecr;
  logic [ECR_W-1:0] d_ecr;
  logic [3:0]       t_idx;
  logic             dma_ok;
  logic             data_q;

  assign q_ecr = ecr_q[qry_idx_i];
  assign d_ecr = ecr_q[dma_cfg_q[3:0]];
  assign dma_ok = dma_cfg_q[DMA_EN_BIT] && dma_cfg_q[3:0] >= PROG_FIRST
                  && d_ecr[ECR_EN_BIT];
  // Endpoint zero maps by direction; endpoint n sits at index n plus one.
  assign t_idx = tok_ep_i == 4'h0 ? (tok_in_i ? CTL_IN_IDX : CTL_OUT_IDX)
                                  : tok_ep_i + 4'h1;

  // The largest packet follows the configured size; control is fixed.
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      qry_base_o      <= '0;
      qry_max_pkt_o   <= '0;
      qry_enabled_o   <= 1'b0;
      qry_direction_o <= 1'b0;
    end
    else
    begin
      qry_base_o <= base_q[qry_idx_i];
      if (qry_idx_i < PROG_FIRST)
      begin
        qry_max_pkt_o   <= CTL_BYTES[PKT_W-1:0];
        qry_enabled_o   <= 1'b1;
        qry_direction_o <= qry_idx_i == CTL_IN_IDX;
      end
      else
      begin
        qry_max_pkt_o   <= q_ecr[ECR_EN_BIT] ?
                           uefa_logical_size(q_ecr[ECR_ISO_BIT], q_ecr[ECR_SZ_LSB +: SZ_W])
                           : '0;
        qry_enabled_o   <= q_ecr[ECR_EN_BIT];
        qry_direction_o <= q_ecr[ECR_DIR_BIT];
      end
    end
  end

  // DMA direction comes from the chosen endpoint: IN means the bus writes it.
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      dma_endpoint_index_o <= 4'h0;
      dma_sel_valid_o      <= 1'b0;
      dma_write_o          <= 1'b0;
    end
    else
    begin
      dma_endpoint_index_o <= dma_cfg_q[3:0];
      dma_sel_valid_o      <= dma_ok;
      dma_write_o          <= dma_ok && d_ecr[ECR_DIR_BIT];
    end
  end

  // A token hits only when address, number and direction all agree.
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      tok_match_o <= 1'b0;
      tok_idx_o   <= 4'h0;
    end
    else
    begin
      tok_idx_o   <= t_idx;
      tok_match_o <= tok_addr_i == dev_addr_i && tok_ep_i != LAST_IDX &&
                     (tok_ep_i == 4'h0 ||
                      (ecr_q[t_idx][ECR_EN_BIT] && ecr_q[t_idx][ECR_DIR_BIT] == tok_in_i));
    end
  end

  // Stall set wins over the clear by an empty packet in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (clr)
    begin
      ctl_in_stalled_o <= 1'b0;
      ctl_in_zlp_o     <= 1'b0;
      data_q           <= 1'b0;
    end
    else
    begin
      ctl_in_zlp_o <= link.ctl_zlp;
      data_q       <= fifo_data_present_i;
      if (link.ctl_stall)
        ctl_in_stalled_o <= 1'b1;
      else if (link.ctl_zlp)
        ctl_in_stalled_o <= 1'b0;
    end
  end

  assign link.alloc_busy   = busy_q;
  assign link.alloc_done   = done_q;
  assign link.size_err     = err_q;
  assign link.total_phys   = tot_q;
  assign link.noniso_phys  = non_q;
  assign link.data_present = data_q;
endmodule // uefa_device
`default_nettype wire

/* File: verification/uefa_link_properties.sv */
// Concurrent checks on the link between controller and allocator.
`timescale 1ns/100ps
`default_nettype none
module uefa_link_properties
  import uefa_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ecr_wr,
  input  wire logic [3:0]       ecr_idx,
  input  wire logic             alloc_busy,
  input  wire logic             alloc_done,
  input  wire logic             size_err,
  input  wire logic [SUM_W-1:0] total_phys,
  input  wire logic [SUM_W-1:0] noniso_phys,
  input  wire logic             ctl_zlp,
  input  wire logic             ctl_stall
);
  // ********************************************************
  // A result is bad on a reserved code or on either sum over its limit.
  // ********************************************************
  wire bad = size_err || (total_phys > TOTAL_MAX) || (noniso_phys > NONISO_MAX);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Sums and the done flag come out of reset in their empty state.
  a_reset_sums_empty: assert property ($rose(rst_n_i) |-> total_phys == CTL_PAIR &&
    noniso_phys == CTL_PAIR && !alloc_done) else $error("sums not empty after reset");
  // The control pair always holds its storage, counted in both sums.
  a_ctl_pair_floor: assert property (total_phys >= CTL_PAIR && noniso_phys >= CTL_PAIR
    && noniso_phys <= total_phys) else $error("control pair storage missing");
  a_busy_after_last: assert property (ecr_wr && ecr_idx == LAST_IDX |=> alloc_busy)
    else $error("walk did not start");
  a_done_walk_time: assert property (ecr_wr && ecr_idx == LAST_IDX |-> ##15 alloc_done)
    else $error("walk length wrong");
  a_done_not_busy: assert property (alloc_done |-> !alloc_busy)
    else $error("done while busy");
  // Values are sent in endpoint order, starting at the control OUT entry.
  a_idx_start: assert property ($rose(ecr_wr) |-> ecr_idx == CTL_OUT_IDX)
    else $error("sequence not from entry 0");
  a_idx_order: assert property (ecr_wr && ecr_idx != LAST_IDX |=>
    ecr_wr && ecr_idx == $past(ecr_idx) + 4'h1) else $error("sequence out of order");
  a_zlp_on_ok: assert property ($rose(alloc_done) ##1 !bad |-> ##[0:2] ctl_zlp)
    else $error("no empty packet after good result");
  a_stall_on_bad: assert property ($rose(alloc_done) ##1 bad |-> ##[0:2] ctl_stall)
    else $error("no stall after bad result");
  a_zlp_stall_excl: assert property (!(ctl_zlp && ctl_stall))
    else $error("empty packet and stall together");
  c_walk: cover property ($rose(alloc_done));
  c_zlp: cover property (ctl_zlp);
  c_stall: cover property (ctl_stall);
endmodule // uefa_link_properties
`default_nettype wire

/* File: verification/usb_endpoint_fifo_allocator_tb.sv */
// Self-checking bench: controller and allocator joined over the link.
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_fifo_allocator_tb;
  import uefa_pkg::*;
  logic        clk_i, rst_n_i, wr_i, rd_i, bus_rst, fdp, qen, qdir;
  logic        dv, dw, tin, tm, stl, zlp;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata;
  logic [3:0]  qidx, didx, tep, tidx;
  logic [14:0] qbase;
  logic [10:0] qmax;
  logic [6:0]  dev_a, tok_a;
  int          n_mismatch, check_count, i;
  logic [10:0] sz [21] = '{11'h010, 11'h020, 11'h030, 11'h040, 11'h060, 11'h080,
    11'h0A0, 11'h0C0, 11'h100, 11'h140, 11'h180, 11'h200, 11'h280, 11'h300,
    11'h380, 11'h3FF, 11'h008, 11'h010, 11'h020, 11'h040, 11'h000};

  uefa_link_if link ();
  uefa_device u_uefa_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .usb_bus_reset_i(bus_rst), .fifo_data_present_i(fdp), .qry_idx_i(qidx),
    .qry_base_o(qbase), .qry_max_pkt_o(qmax), .qry_enabled_o(qen), .qry_direction_o(qdir),
    .dma_endpoint_index_o(didx), .dma_sel_valid_o(dv), .dma_write_o(dw), .dev_addr_i(dev_a),
    .tok_addr_i(tok_a), .tok_ep_i(tep), .tok_in_i(tin), .tok_match_o(tm), .tok_idx_o(tidx),
    .ctl_in_stalled_o(stl), .ctl_in_zlp_o(zlp));
  uefa_host u_uefa_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata));
  uefa_link_properties u_uefa_link_properties (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ecr_wr(link.ecr_wr), .ecr_idx(link.ecr_idx), .alloc_busy(link.alloc_busy),
    .alloc_done(link.alloc_done), .size_err(link.size_err), .total_phys(link.total_phys),
    .noniso_phys(link.noniso_phys), .ctl_zlp(link.ctl_zlp), .ctl_stall(link.ctl_stall));

  // ********************************************************
  // Clock and access tasks.
  // ********************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A strobe is dropped for one cycle between accesses so no signal is set twice at once.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wr_i <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Read data are taken in the single cycle after the strobe.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rd_i <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    chk({16'h0000, rdata}, {16'h0000, e});
  endtask

  task automatic cfg(input logic [3:0] n, input logic [7:0] v);
    wr({1'b0, n}, {8'h00, v});
  endtask

  // Starts a walk and waits, bounded, for the verdict pulse on the link.
  task automatic go(input logic [15:0] st);
    int k;
    wr(RA_CTRL, 16'h0003);
    for (k = 0; k < 80 && !(link.ctl_zlp | link.ctl_stall); k++)
      @(posedge clk_i);
    if (k == 80)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no verdict", $time);
      report_and_stop();
    end
    @(posedge clk_i);
    chk({31'h0, zlp}, {31'h0, st[ST_OK_BIT]});
    @(posedge clk_i);
    rd(RA_STATUS, st);
  endtask

  task automatic q(input logic [3:0] n, input logic [14:0] b, input logic [10:0] m,
                   input logic [1:0] ed);
    qidx <= n;
    repeat (2) @(posedge clk_i);
    chk({4'h0, qbase, qmax, qen, qdir}, {4'h0, b, m, ed});
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  // ********************************************************
  // Test sequence.
  // ********************************************************
  initial
  begin
    {rst_n_i, wr_i, rd_i, bus_rst, fdp, tin} = 6'h00;
    {addr, wdata, qidx, tep} = '0;
    {dev_a, tok_a} = {7'h05, 7'h05};
    n_mismatch = 0;
    check_count = 0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(RA_STATUS, 16'h0000);
    rd(RA_TOTAL, 16'h0080);
    q(CTL_IN_IDX, 15'h0040, 11'h040, 2'b11);
    q(4'h2, 15'h0000, 11'h000, 2'b00);
    fin("reset");
    cfg(4'h2, 8'hFF);
    cfg(4'h3, 8'h33);
    cfg(4'h4, 8'h81);
    cfg(4'h5, 8'hD3);
    go(16'h0012);
    rd(RA_TOTAL, 16'h090E);
    rd(RA_NONISO, 16'h0110);
    chk({31'h0, stl}, 32'h0);
    q(4'h2, 15'h0080, 11'h3FF, 2'b11);
    q(4'h3, 15'h087E, 11'h000, 2'b00);
    q(4'h4, 15'h087E, 11'h010, 2'b10);
    q(4'h5, 15'h088E, 11'h040, 2'b11);
    q(4'h6, 15'h090E, 11'h000, 2'b00);
    fin("layout");
    for (i = 0; i < 5; i++)
    begin
      {tok_a, tep, tin} <= {i == 2 ? 7'h06 : 7'h05, i == 4 ? 4'h0 : i < 2 ? 4'h1 : 4'h3,
                            i != 1 && i != 3};
      repeat (2) @(posedge clk_i);
      chk({27'h0, tm, tm ? tidx : 4'h0}, {27'h0, i == 0 ? 5'h12 : i == 3 ? 5'h14 :
          i == 4 ? 5'h11 : 5'h00});
    end
    fin("token");
    for (i = 0; i < 5; i++)
    begin
      wr(RA_DMA, {8'h00, i == 0 ? 8'h12 : i == 1 ? 8'h14 : i == 2 ? 8'h11 : 8'h03 + 8'h10 *
         8'(i - 3)});
      repeat (3) @(posedge clk_i);
      chk({26'h0, didx, dv, dw}, {26'h0, i == 0 ? 6'h0B : i == 1 ? 6'h12 : i == 2 ? 6'h04 :
          6'h0C});
    end
    fin("dma");
    fdp <= 1'b1;
    repeat (2) @(posedge clk_i);
    wr(RA_CTRL, 16'h0003);
    rd(RA_STATUS, 16'h001A);
    fdp <= 1'b0;
    wr(RA_STATUS, 16'h0008);
    rd(RA_STATUS, 16'h0012);
    fin("refused");
    for (i = 0; i < 21; i++)
    begin
      cfg(4'h2, i < 16 ? 8'hA0 | 8'(i) : 8'h80 | 8'(i - 16));
      go(i == 20 ? 16'h0004 : 16'h0012);
      q(4'h2, 15'h0080, sz[i], 2'b10);
    end
    chk({31'h0, stl}, 32'h1);
    fin("sizes");
    cfg(4'h2, 8'hBF);
    cfg(4'h6, 8'hB8);
    go(16'h0004);
    cfg(4'h2, 8'h00);
    cfg(4'h6, 8'h93);
    cfg(4'h7, 8'h83);
    cfg(4'h8, 8'h82);
    cfg(4'h9, 8'h81);
    go(16'h0012);
    chk({31'h0, stl}, 32'h0);
    wr(RA_CTRL, 16'h0000);
    rd(RA_STATUS, 16'h0002);
    cfg(4'h9, 8'h82);
    go(16'h0004);
    fin("limits");
    bus_rst <= 1'b1;
    repeat (2) @(posedge clk_i);
    bus_rst <= 1'b0;
    q(4'h6, 15'h0000, 11'h000, 2'b00);
    q(CTL_OUT_IDX, 15'h0000, 11'h040, 2'b10);
    rd(RA_TOTAL, 16'h0080);
    fin("bus reset");
    report_and_stop();
  end
endmodule // usb_endpoint_fifo_allocator_tb
`default_nettype wire
